/* core/fsr_regs.svh */
// Constants for the flash status polling controller
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH
// Status bit positions on the data bus
`define FSR_POLL_POS 7
`define FSR_TOG1_POS 6
`define FSR_TLIM_POS 5
`define FSR_EWIN_POS 3
`define FSR_TOG2_POS 2
// Bus timing in ns and derived cycles at 5 ns
`define FSR_CLK_NS 5
`define FSR_T_ACC_NS 70
`define FSR_ACC_CYC ((`FSR_T_ACC_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_T_HIGH_NS 30
`define FSR_HIGH_CYC ((`FSR_T_HIGH_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)
`define FSR_CNT_W 5
`endif

/* core/fsr_pkg.sv */
// Types for the flash status polling controller
package fsr_pkg;
  typedef enum logic [2:0] {
    FSR_IDLE,
    FSR_FIRST,
    FSR_SECOND,
    FSR_THIRD,
    FSR_FINAL
  } fsr_state_t;
  typedef enum logic [1:0] {
    FSR_RES_OK,
    FSR_RES_FAIL,
    FSR_RES_ABORT
  } fsr_result_t;
endpackage : fsr_pkg

/* core/fsr_read_cycle.sv */
// One framed read cycle on the flash bus
`timescale 1ns/1ps
`include "fsr_regs.svh"
module fsr_read_cycle (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [21:0] addr,
  input wire logic [7:0] dq_in,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic [21:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n
);
  typedef struct packed {
    logic busy;
    logic done;
    logic low;
    logic [`FSR_CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic [21:0] addr;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
  } fsr_rc_t;
  fsr_rc_t q;
  fsr_rc_t next_q;
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    // Three stages on the asynchronous data bus
    next_q.s1 = dq_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (!q.busy) begin
      if (start) begin
        next_q.busy = 1'b1;
        next_q.low = 1'b1;
        next_q.addr = addr;
        next_q.cnt = `FSR_CNT_W'(`FSR_ACC_CYC + 3);
      end
    end else if (q.cnt != '0) begin
      next_q.cnt = q.cnt - 1'b1;
    end else if (q.low) begin
      // Strobes rise here; device toggles its bits on this edge
      next_q.low = 1'b0;
      next_q.rdata = q.s3;
      next_q.cnt = `FSR_CNT_W'(`FSR_HIGH_CYC);
    end else begin
      next_q.busy = 1'b0;
      next_q.done = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end
  assign busy = q.busy;
  assign done = q.done;
  assign rdata = q.rdata;
  assign flash_addr = q.addr;
  assign flash_ce_n = ~q.low;
  assign flash_oe_n = ~q.low;
endmodule : fsr_read_cycle

/* core/fsr_status_poll.sv */
// Host-side toggle-bit status polling controller for a parallel flash
// Overview of operation
// - Poll at programmed or erasing-sector address
// - Read again after toggle one stops
// - Read full byte twice back to back
// - No toggle: done, array reads next
// - Time limit high: recheck, else reset
// - Resumed polling restarts from first read
// - Combine toggle one and two
`timescale 1ns/1ps
`include "fsr_regs.svh"

module fsr_status_poll (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic abort,
  input wire logic [21:0] poll_addr,
  input wire logic [7:0] dq_in,
  input wire logic ready_busy_n,
  output logic [21:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic dq_oe,
  output logic busy,
  output logic done,
  output logic [1:0] result,
  output logic [7:0] final_data,
  output logic erase_suspended,
  output logic sector_erasing,
  output logic erase_window_flag,
  output logic dev_ready
);

  // All polling state in one record; the leaf keeps its own
  typedef struct packed {
    fsr_pkg::fsr_state_t st;
    logic busy;
    logic issued;
    logic [7:0] first;
    logic done;
    fsr_pkg::fsr_result_t result;
    logic [7:0] data;
    logic susp;
    logic erasing;
    logic ewin;
    logic [2:0] rb;
    logic rdy;
  } fsr_sp_t;
  fsr_sp_t q;
  fsr_sp_t next_q;

  // Leaf read engine and per-bit compare of two reads
  logic rc_busy;
  logic rc_done;
  logic [7:0] rc_data;
  logic [21:0] rc_addr;
  logic rc_ce_n;
  logic rc_oe_n;
  logic rc_start;
  logic tog1;
  logic tog2;
  wire logic [7:0] diff;

  fsr_read_cycle u_read (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(rc_start),
    .addr(poll_addr),
    .dq_in(dq_in),
    .busy(rc_busy),
    .done(rc_done),
    .rdata(rc_data),
    .flash_addr(rc_addr),
    .flash_ce_n(rc_ce_n),
    .flash_oe_n(rc_oe_n)
  );

  // Compare across completed read cycles
  // Device flips its toggle bits once per completed read, so two
  // back-to-back bytes differ exactly where a toggle bit is live
  for (genvar i = 0; i < 8; i++) begin : g_diff
    assign diff[i] = rc_data[i] ^ q.first[i];
  end
  assign tog1 = diff[`FSR_TOG1_POS];
  assign tog2 = diff[`FSR_TOG2_POS];

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    rc_start = 1'b0;

    // Ready/busy pin is asynchronous; accept when stages two, three agree
    next_q.rb = {q.rb[1:0], ready_busy_n};

    if (q.rb[2] == q.rb[1]) begin
      next_q.rdy = q.rb[2];
    end

    // One read in flight at a time; the leaf latches the address
    if (q.st != fsr_pkg::FSR_IDLE && !q.issued && !rc_busy) begin
      rc_start = 1'b1;
      next_q.issued = 1'b1;
    end

    case (q.st)
      fsr_pkg::FSR_IDLE: begin
        // Every start begins at the first read
        if (start) begin
          next_q.st = fsr_pkg::FSR_FIRST;
          next_q.issued = 1'b0;
        end
      end

      fsr_pkg::FSR_FIRST: begin
        if (rc_done) begin
          next_q.first = rc_data;
          next_q.st = fsr_pkg::FSR_SECOND;
          next_q.issued = 1'b0;
        end
      end

      fsr_pkg::FSR_SECOND, fsr_pkg::FSR_THIRD: begin
        if (rc_done) begin
          // Mode from toggle one, sector from toggle two
          next_q.susp = ~tog1 & tog2;
          next_q.erasing = tog1 & tog2;
          // Erase window state seen this read
          next_q.ewin = rc_data[`FSR_EWIN_POS];
          next_q.issued = 1'b0;
          next_q.first = rc_data;

          // Keep this byte as the reference for any further compare
          if (!tog1) begin
            // Finished; confirm with a fresh read
            next_q.st = fsr_pkg::FSR_FINAL;
          end else if (q.st == fsr_pkg::FSR_THIRD) begin
            // Still toggling after time limit
            // Caller must issue the device reset command next
            next_q.st = fsr_pkg::FSR_IDLE;
            next_q.result = fsr_pkg::FSR_RES_FAIL;
            next_q.done = 1'b1;
          end else if (rc_data[`FSR_TLIM_POS]) begin
            // Time limit seen; one more check
            next_q.st = fsr_pkg::FSR_THIRD;
          end else if (abort) begin
            // Only between pairs, so a later start restarts cleanly
            next_q.st = fsr_pkg::FSR_IDLE;
            next_q.result = fsr_pkg::FSR_RES_ABORT;
            next_q.done = 1'b1;
          end
        end
      end

      fsr_pkg::FSR_FINAL: begin
        // Valid byte from the following cycle
        if (rc_done) begin
          next_q.data = rc_data;
          next_q.result = fsr_pkg::FSR_RES_OK;
          next_q.done = 1'b1;
          next_q.st = fsr_pkg::FSR_IDLE;
        end
      end

      default: begin
        next_q.st = fsr_pkg::FSR_IDLE;
      end
    endcase

    // Busy from a flop so the output has no decode glitch
    next_q.busy = (next_q.st != fsr_pkg::FSR_IDLE);
  end

  // Clock enable low freezes every field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // Read-cycle outputs are registered in the leaf
  assign flash_addr = rc_addr;
  assign flash_ce_n = rc_ce_n;
  assign flash_oe_n = rc_oe_n;

  // No writes: command issue is outside this block
  assign flash_we_n = 1'b1;
  assign dq_oe = 1'b0;

  assign busy = q.busy;
  assign done = q.done;
  assign result = q.result;
  assign final_data = q.data;
  assign erase_suspended = q.susp;
  assign sector_erasing = q.erasing;
  assign erase_window_flag = q.ewin;
  assign dev_ready = q.rdy;
endmodule : fsr_status_poll

/* tb/fsr_status_poll_props.sv */
// Port assertions for the status polling controller
`timescale 1ns/1ps
module fsr_status_poll_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic [21:0] poll_addr,
  input wire logic [21:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic busy,
  input wire logic done,
  input wire logic [1:0] result
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_addr; !flash_ce_n |-> flash_addr == poll_addr; endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_hold; $fell(flash_oe_n) |-> !flash_oe_n [*8]; endproperty
  a_hold: assert property (p_hold) else $error("short read");
  property p_frame; !flash_oe_n |-> !flash_ce_n; endproperty
  a_frame: assert property (p_frame) else $error("unframed read");
  property p_next;
    $rose(flash_oe_n) && busy |-> ##[1:16] ($fell(flash_oe_n) || done);
  endproperty
  a_next: assert property (p_next) else $error("reads apart");
  property p_done; done |-> flash_ce_n && flash_oe_n ##1 !done; endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_res; done |-> result != 2'h3; endproperty
  a_res: assert property (p_res) else $error("bad result");
  property p_keep; !done |-> $stable(result); endproperty
  a_keep: assert property (p_keep) else $error("result moved");
  property p_start;
    clk_en && start && !busy |=> busy ##[0:3] !flash_ce_n;
  endproperty
  a_start: assert property (p_start) else $error("no first read");
endmodule : fsr_status_poll_props
bind fsr_status_poll fsr_status_poll_props u_props (.clk, .sys_rst, .clk_en,
  .start, .poll_addr, .flash_addr, .flash_ce_n, .flash_oe_n, .busy, .done,
  .result);

/* tb/fsr_flash_model.sv */
// Behavioural flash answering status reads
`timescale 1ns/1ps
module fsr_flash_model (
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  output logic [7:0] dq,
  output logic ready_busy_n
);
  logic [7:0] data = 8'h5A;
  logic [3:0] left = 4'h0;
  logic tlim = 1'b0;
  logic sec = 1'b0;
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic act;
  assign act = !flash_ce_n && !flash_oe_n;
  // status for a count of reads or while sec is set, then array data
  always @(negedge act) begin
    last <= val;
    if (left != 4'h0) begin
      tog1 <= ~tog1;
      left <= left - 4'h1;
    end
    if (sec) tog2 <= ~tog2;
  end
  always_comb begin
    val = data;
    if (left != 4'h0 || sec)
      val = {left != 4'h0 ? ~data[7] : 1'b1, tog1, tlim, 2'b01,
        sec ? tog2 : 1'b1, 2'b00};
  end
  // Released bus never holds the last byte
  assign dq = act ? val : ~last;
  assign ready_busy_n = left == 4'h0;
endmodule : fsr_flash_model

/* tb/test_fsr_status_poll.sv */
// Self-checking bench for the status polling controller
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_fsr_status_poll;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  logic abort = 1'b0;
  logic [21:0] poll_addr = 22'h012345;
  logic [7:0] dq_in;
  logic ready_busy_n, flash_ce_n, flash_oe_n, busy, done, erase_suspended;
  logic sector_erasing, erase_window_flag, dev_ready;
  logic [21:0] flash_addr;
  logic [1:0] result;
  logic [7:0] final_data;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  fsr_status_poll dut_u (.clk, .sys_rst, .clk_en, .start, .abort,
    .poll_addr, .dq_in, .ready_busy_n, .flash_addr, .flash_ce_n,
    .flash_oe_n, .flash_we_n(), .dq_oe(), .busy, .done, .result,
    .final_data, .erase_suspended, .sector_erasing,
    .erase_window_flag, .dev_ready);
  fsr_flash_model fm (.flash_ce_n, .flash_oe_n, .dq(dq_in), .ready_busy_n);
  initial forever #2.5 clk = ~clk;
  task results;
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task run(input logic [3:0] l, input logic t, s, a, input logic [1:0] r);
    int k;
    fm.left = l;
    fm.tlim = t;
    fm.sec = s;
    abort = a;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    `CHK(done, 1'b1)
    `CHK(result, r)
  endtask : run
  initial begin
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    run(4'h0, 1'b0, 1'b0, 1'b0, 2'h0);
    `CHK(final_data, 8'h5A)
    `CHK(erase_suspended, 1'b0)
    `CHK(dev_ready, 1'b1)
    run(4'h3, 1'b0, 1'b0, 1'b0, 2'h0);
    `CHK(final_data, 8'h5A)
    run(4'hF, 1'b1, 1'b0, 1'b0, 2'h1);
    `CHK(dev_ready, 1'b0)
    run(4'hF, 1'b0, 1'b0, 1'b1, 2'h2);
    run(4'hF, 1'b1, 1'b1, 1'b0, 2'h1);
    `CHK(sector_erasing, 1'b1)
    run(4'h0, 1'b0, 1'b1, 1'b0, 2'h0);
    `CHK(erase_suspended, 1'b1)
    `CHK(sector_erasing, 1'b0)
    `CHK(erase_window_flag, 1'b1)
    results();
  end
endmodule : test_fsr_status_poll
